// [rtl/lcesc_ctrl.sv]
// Control register, channel decode gating, address gate and shutdown arming.
// Assumes an AXI4-Lite master on clock; host LPC side sampled on the same clock.
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module lcesc_ctrl (
	input  wire logic                 clock,
	input  wire logic                 resetn,
	input  wire logic                 lpc_soft_reset,
	input  wire logic [7:0]           s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [7:0]           s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	input  wire lcesc_pkg::lcesc_hreq_s host_req,
	input  wire logic                 ch3_addr_match,
	output lcesc_pkg::lcesc_hit_s     host_hit,
	output logic                      host_if_enable,
	input  wire logic                 power_down_input_n,
	output logic                      hw_shutdown,
	input  wire logic                 gate_cmd_valid,
	input  wire logic                 gate_cmd_value,
	output logic                      address_gate_out,
	output logic                      gate_port_pin_oe_n,
	output logic                      gate_port_pin_sel
);
	// ********************************************************************
	// Pin synchroniser for the power-down input.
	// ********************************************************************
	logic pd_meta;
	logic pd_sync;
	logic pd_prev;

	// Two flops before use; the first flop feeds nothing else.
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pd_meta <= 1'b1;
			pd_sync <= 1'b1;
			pd_prev <= 1'b1;
		end else begin
			pd_meta <= power_down_input_n;
			pd_sync <= pd_meta;
			pd_prev <= pd_sync;
		end
	end

	// ********************************************************************
	// AXI4-Lite slave.
	// ********************************************************************
	logic       aw_held, next_aw_held;
	logic       w_held, next_w_held;
	logic [7:0] aw_addr, next_aw_addr;
	logic [7:0] w_byte, next_w_byte;
	logic       w_lane0, next_w_lane0;
	logic       bvalid, next_bvalid;
	logic [1:0] bresp, next_bresp;
	logic       rvalid, next_rvalid;
	logic [1:0] rresp, next_rresp;
	logic [31:0] rdata, next_rdata;
	logic       wr_fire;
	logic       rd_fire;
	logic       wr_hit;
	logic       rd_ctrl;

	// Ready while nothing of that channel is held and no response pends.
	assign s_axi_awready = !aw_held && !bvalid;
	assign s_axi_wready  = !w_held && !bvalid;
	assign s_axi_arready = !rvalid;
	assign s_axi_bvalid  = bvalid;
	assign s_axi_bresp   = bresp;
	assign s_axi_rvalid  = rvalid;
	assign s_axi_rresp   = rresp;
	assign s_axi_rdata   = rdata;

	logic [7:0] ctrl0, next_ctrl0;
	logic       sd_armed, next_sd_armed;
	logic       in_shutdown;

	// Channel handshake and register read data.
	always_comb begin
		next_aw_held = aw_held;
		next_aw_addr = aw_addr;
		next_w_held  = w_held;
		next_w_byte  = w_byte;
		next_w_lane0 = w_lane0;
		next_bvalid  = bvalid;
		next_bresp   = bresp;
		next_rvalid  = rvalid;
		next_rresp   = rresp;
		next_rdata   = rdata;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held  = 1'b1;
			next_w_byte  = s_axi_wdata[7:0];
			next_w_lane0 = s_axi_wstrb[0];
		end
		if (wr_fire) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = wr_hit ? lcesc_pkg::RESP_OKAY : lcesc_pkg::RESP_SLVERR;
		end else if (bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		if (rd_fire) begin
			next_rvalid = 1'b1;
			next_rresp  = lcesc_pkg::RESP_OKAY;
			if (s_axi_araddr == lcesc_pkg::CTRL0_ADDR) begin
				next_rdata = {24'h000000, ctrl0};
			end else if (s_axi_araddr == lcesc_pkg::STATUS_ADDR) begin
				next_rdata = {28'h0000000, sd_armed, in_shutdown, address_gate_out,
					host_if_enable};
			end else begin
				next_rdata = 32'h00000000;
				next_rresp = lcesc_pkg::RESP_SLVERR;
			end
		end else if (rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
	end

	assign wr_fire = aw_held && w_held && !bvalid;
	assign rd_fire = s_axi_arvalid && s_axi_arready;
	assign wr_hit  = (aw_addr == lcesc_pkg::CTRL0_ADDR);
	assign rd_ctrl = rd_fire && (s_axi_araddr == lcesc_pkg::CTRL0_ADDR);

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			aw_held <= 1'b0;
			aw_addr <= 8'h00;
			w_held  <= 1'b0;
			w_byte  <= 8'h00;
			w_lane0 <= 1'b0;
			bvalid  <= 1'b0;
			bresp   <= 2'h0;
			rvalid  <= 1'b0;
			rresp   <= 2'h0;
			rdata   <= 32'h00000000;
		end else begin
			aw_held <= next_aw_held;
			aw_addr <= next_aw_addr;
			w_held  <= next_w_held;
			w_byte  <= next_w_byte;
			w_lane0 <= next_w_lane0;
			bvalid  <= next_bvalid;
			bresp   <= next_bresp;
			rvalid  <= next_rvalid;
			rresp   <= next_rresp;
			rdata   <= next_rdata;
		end
	end

	// ********************************************************************
	// Control register and shutdown enable.
	// ********************************************************************
	logic ctrl_wr;
	logic pd_release;

	assign ctrl_wr    = wr_fire && wr_hit && w_lane0;
	assign pd_release = pd_sync && !pd_prev;

	// The shutdown bit guards against a stray set: a 1 only lands after software
	// has seen it at 0, so a blind write cannot arm it.
	always_comb begin
		next_ctrl0    = ctrl0;
		next_sd_armed = sd_armed;
		if (rd_ctrl && !ctrl0[lcesc_pkg::SDWN_BIT]) begin
			next_sd_armed = 1'b1;
		end
		if (ctrl_wr) begin
			next_ctrl0[7:4] = w_byte[7:4];
			if (!w_byte[lcesc_pkg::SDWN_BIT]) begin
				next_ctrl0[lcesc_pkg::SDWN_BIT] = 1'b0;
			end else if (sd_armed) begin
				next_ctrl0[lcesc_pkg::SDWN_BIT] = 1'b1;
			end
			next_sd_armed = 1'b0;
		end
		if (pd_release || lpc_soft_reset) begin
			next_ctrl0[lcesc_pkg::SDWN_BIT] = 1'b0;
			next_sd_armed = 1'b0;
		end
		next_ctrl0[2:0] = 3'h0;
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ctrl0    <= lcesc_pkg::CTRL0_RESET;
			sd_armed <= 1'b0;
		end else begin
			ctrl0    <= next_ctrl0;
			sd_armed <= next_sd_armed;
		end
	end

	// ********************************************************************
	// Shutdown, host enable and address decode gating.
	// ********************************************************************
	// Power-down low shuts the module whether or not software armed it.
	assign in_shutdown    = !pd_sync;
	assign hw_shutdown    = in_shutdown;
	assign host_if_enable = |ctrl0[7:5] && !in_shutdown;

	// Host hits only reach a channel while that channel is enabled.
	always_comb begin
		host_hit.ch1 = host_if_enable && ctrl0[lcesc_pkg::CH1_BIT] && host_req.valid &&
			(host_req.addr == lcesc_pkg::CH1_DATA_IO ||
			 host_req.addr == lcesc_pkg::CH1_STAT_IO);
		host_hit.ch2 = host_if_enable && ctrl0[lcesc_pkg::CH2_BIT] && host_req.valid &&
			(host_req.addr == lcesc_pkg::CH2_DATA_IO ||
			 host_req.addr == lcesc_pkg::CH2_STAT_IO);
		host_hit.ch3 = host_if_enable && ctrl0[lcesc_pkg::CH3_BIT] && host_req.valid &&
			ch3_addr_match;
	end

	// ********************************************************************
	// Fast address gate.
	// ********************************************************************
	logic gate_state, next_gate_state;

	always_comb begin
		next_gate_state = gate_state;
		if (!ctrl0[lcesc_pkg::FGATE_BIT]) begin
			next_gate_state = 1'b1;
		end else if (gate_cmd_valid) begin
			next_gate_state = gate_cmd_value;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			gate_state <= 1'b1;
		end else begin
			gate_state <= next_gate_state;
		end
	end

	// Open drain: only a low is driven; a high releases the pin to the pull-up.
	assign address_gate_out   = gate_state;
	assign gate_port_pin_sel  = ctrl0[lcesc_pkg::FGATE_BIT];
	assign gate_port_pin_oe_n = !(ctrl0[lcesc_pkg::FGATE_BIT] && !gate_state);

	// ********************************************************************
	// Checks.
	// ********************************************************************
	ch1_gate_a: assert property (@(posedge clock) disable iff (!resetn)
		host_hit.ch1 |-> ctrl0[lcesc_pkg::CH1_BIT]) else $error("ch1 hit while disabled");
	ch2_gate_a: assert property (@(posedge clock) disable iff (!resetn)
		host_hit.ch2 |-> ctrl0[lcesc_pkg::CH2_BIT]) else $error("ch2 hit while disabled");
	ch3_gate_a: assert property (@(posedge clock) disable iff (!resetn)
		host_hit.ch3 |-> ctrl0[lcesc_pkg::CH3_BIT]) else $error("ch3 hit while disabled");
	host_enable_a: assert property (@(posedge clock) disable iff (!resetn)
		host_if_enable == (|ctrl0[7:5] && pd_sync)) else $error("host enable wrong");
	gate_idle_a: assert property (@(posedge clock) disable iff (!resetn)
		!ctrl0[lcesc_pkg::FGATE_BIT] |=> gate_state) else $error("gate not held high");
	gate_od_a: assert property (@(posedge clock) disable iff (!resetn)
		!gate_port_pin_oe_n |-> !address_gate_out) else $error("gate drives high");
	sd_blind_a: assert property (@(posedge clock) disable iff (!resetn)
		(ctrl_wr && !sd_armed && !ctrl0[lcesc_pkg::SDWN_BIT]) |=>
		!ctrl0[lcesc_pkg::SDWN_BIT]) else $error("blind set of shutdown enable");
	sd_release_a: assert property (@(posedge clock) disable iff (!resetn)
		$rose(pd_sync) |=> !ctrl0[lcesc_pkg::SDWN_BIT]) else $error("release kept enable");
	shutdown_a: assert property (@(posedge clock) disable iff (!resetn)
		!pd_sync |-> (hw_shutdown && !host_if_enable)) else $error("no shutdown");
	low_bits_a: assert property (@(posedge clock) disable iff (!resetn)
		ctrl0[2:0] == 3'h0) else $error("reserved bits set");
	wr_cov: cover property (@(posedge clock) disable iff (!resetn) ctrl_wr);
	arm_cov: cover property (@(posedge clock) disable iff (!resetn)
		$rose(ctrl0[lcesc_pkg::SDWN_BIT]));
	hit_cov: cover property (@(posedge clock) disable iff (!resetn) host_hit.ch3);
endmodule // lcesc_ctrl

`default_nettype wire

// [rtl/lcesc_pkg.sv]
// Package for the channel enable and shutdown control block.
// Assumes a 32-bit AXI4-Lite register bus on a single 50 MHz clock.
package lcesc_pkg;
	// ********************************************************************
	// Register map and field layout.
	// ********************************************************************
	localparam logic [7:0] CTRL0_ADDR   = 8'h00; // host_interface_control_0.
	localparam logic [7:0] STATUS_ADDR  = 8'h04; // Live state of the block.
	localparam logic [7:0] CTRL0_RESET  = 8'h00;
	localparam int         CH3_BIT      = 7;
	localparam int         CH2_BIT      = 6;
	localparam int         CH1_BIT      = 5;
	localparam int         FGATE_BIT    = 4;
	localparam int         SDWN_BIT     = 3;
	localparam logic [1:0] RESP_OKAY    = 2'h0;
	localparam logic [1:0] RESP_SLVERR  = 2'h2;
	localparam logic [15:0] CH1_DATA_IO = 16'h0060;
	localparam logic [15:0] CH1_STAT_IO = 16'h0064;
	localparam logic [15:0] CH2_DATA_IO = 16'h0062;
	localparam logic [15:0] CH2_STAT_IO = 16'h0066;

	// Host-side address check request and its answer.
	typedef struct packed {
		logic        valid;
		logic [15:0] addr;
	} lcesc_hreq_s;
	typedef struct packed {
		logic ch1;
		logic ch2;
		logic ch3;
	} lcesc_hit_s;
endpackage

// [verif/lcesc_host_model.sv]
// Behavioural host-side partner: address probes, power-down, soft reset, gate commands.
// Assumes the bench calls its tasks on the shared clock and never two at once.
`timescale 1ns/100ps
`default_nettype none
module lcesc_host_model (
	input  wire logic                  clock,
	output var  lcesc_pkg::lcesc_hreq_s host_req,
	output var  logic                  ch3_addr_match,
	output var  logic                  power_down_input_n,
	output var  logic                  lpc_soft_reset,
	output var  logic                  gate_cmd_valid,
	output var  logic                  gate_cmd_value
);
	// ********************************************************************
	// Host line drivers.
	// ********************************************************************
	// The link starts awake, so power-down rests high.
	initial begin
		host_req = '0;
		ch3_addr_match = 1'b0;
		power_down_input_n = 1'b1;
		lpc_soft_reset = 1'b0;
		gate_cmd_valid = 1'b0;
		gate_cmd_value = 1'b0;
	end
	// One I/O address held for decode, with the channel 3 compare result.
	task automatic probe(input logic [15:0] addr, input logic m);
		@(posedge clock);
		host_req <= {1'b1, addr};
		ch3_addr_match <= m;
	endtask
	// A one-cycle soft reset level.
	task automatic pulse_reset();
		@(posedge clock);
		lpc_soft_reset <= 1'b1;
		@(posedge clock);
		lpc_soft_reset <= 1'b0;
	endtask
	// The value is inverted after the command so a stale level is never trusted.
	task automatic gate(input logic v);
		@(posedge clock);
		gate_cmd_valid <= 1'b1;
		gate_cmd_value <= v;
		@(posedge clock);
		gate_cmd_valid <= 1'b0;
		gate_cmd_value <= ~v;
	endtask
	task automatic set_pd(input logic v);
		@(posedge clock);
		power_down_input_n <= v;
	endtask
endmodule // lcesc_host_model
`default_nettype wire

// [verif/tb_top.sv]
// Self-checking bench for the control register block, driven over AXI4-Lite.
// Assumes the host partner model for all host-side inputs.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	// ********************************************************************
	// Signals, clock and design.
	// ********************************************************************
	logic clock, resetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr, v;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	lcesc_pkg::lcesc_hreq_s host_req;
	lcesc_pkg::lcesc_hit_s host_hit;
	logic ch3_addr_match, host_if_enable, power_down_input_n, hw_shutdown, lpc_soft_reset;
	logic gate_cmd_valid, gate_cmd_value, address_gate_out, gate_port_pin_oe_n, gate_port_pin_sel;
	int fail_count = 0;
	int n_checks = 0;
	logic [3:0] lanes = 4'h1;
	logic [7:0] tbl [5] = '{8'h00, 8'h20, 8'h40, 8'h80, 8'hE0};
	logic [15:0] io [4] = '{16'h0060, 16'h0064, 16'h0062, 16'h0066};
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	lcesc_ctrl dut (.clock, .resetn, .lpc_soft_reset, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .host_req, .ch3_addr_match,
		.host_hit, .host_if_enable, .power_down_input_n, .hw_shutdown, .gate_cmd_valid,
		.gate_cmd_value, .address_gate_out, .gate_port_pin_oe_n, .gate_port_pin_sel);
	lcesc_host_model host (.clock, .host_req, .ch3_addr_match, .power_down_input_n,
		.lpc_soft_reset, .gate_cmd_valid, .gate_cmd_value);
	// ********************************************************************
	// Bus tasks and checking.
	// ********************************************************************
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// Handshakes are judged at the falling edge, where every ready has settled.
	task automatic wr(input logic [7:0] a, input logic [7:0] val, output logic [1:0] b);
		int i;
		logic aw, w, bv;
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, val};
		s_axi_wstrb <= lanes;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(negedge clock);
			aw = s_axi_awvalid & s_axi_awready;
			w = s_axi_wvalid & s_axi_wready;
			bv = s_axi_bvalid;
			b = s_axi_bresp;
			@(posedge clock);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
			if (bv) begin
				s_axi_bready <= 1'b0;
				break;
			end
		end
		if (i == 20) begin
			fail_count++;
			conclude();
		end
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] rr);
		int i;
		logic ar, rv;
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(negedge clock);
			ar = s_axi_arvalid & s_axi_arready;
			rv = s_axi_rvalid;
			dat = s_axi_rdata;
			rr = s_axi_rresp;
			@(posedge clock);
			if (ar) s_axi_arvalid <= 1'b0;
			if (rv) begin
				s_axi_rready <= 1'b0;
				break;
			end
		end
		if (i == 20) begin
			fail_count++;
			conclude();
		end
	endtask
	// ********************************************************************
	// Test sequence.
	// ********************************************************************
	initial begin
		resetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h00000000;
		s_axi_wstrb = 4'h1;
		repeat (4) @(posedge clock);
		resetn <= 1'b1;
		rd(8'h00, d, r);
		chk("ctrl reset", d, 32'h00000000);
		rd(8'h04, d, r);
		chk("status reset", d, 32'h0000000A);
		wr(8'h08, 8'hFF, r);
		chk("unmapped wresp", 32'(r), 32'(lcesc_pkg::RESP_SLVERR));
		rd(8'h08, d, r);
		chk("unmapped rresp", 32'(r), 32'(lcesc_pkg::RESP_SLVERR));
		$display("test reset and map done");
		// Each enable pattern is probed at all four fixed ports and a near miss.
		foreach (tbl[i]) begin
			v = tbl[i];
			wr(8'h00, v, r);
			rd(8'h00, d, r);
			chk("ctrl readback", d, {24'h000000, v});
			chk("host enable", 32'(host_if_enable), 32'(|v[7:5]));
			foreach (io[j]) begin
				host.probe(io[j], 1'b1);
				@(negedge clock);
				chk("hit", 32'(host_hit), {29'h0, v[5] & (j < 2), v[6] & (j >= 2), v[7]});
			end
			host.probe(16'h0061, 1'b0);
			@(negedge clock);
			chk("miss", 32'(host_hit), 32'h00000000);
		end
		$display("test channel enables done");
		wr(8'h00, 8'h10, r);
		@(negedge clock);
		chk("gate sel on", 32'(gate_port_pin_sel), 32'h1);
		host.gate(1'b0);
		@(negedge clock);
		chk("gate out low", 32'(address_gate_out), 32'h0);
		chk("gate drive", 32'(gate_port_pin_oe_n), 32'h0);
		host.gate(1'b1);
		@(negedge clock);
		chk("gate release", 32'(gate_port_pin_oe_n), 32'h1);
		host.gate(1'b0);
		wr(8'h00, 8'h00, r);
		host.gate(1'b0);
		@(negedge clock);
		chk("gate sel off", 32'(gate_port_pin_sel), 32'h0);
		chk("gate held", 32'(address_gate_out), 32'h1);
		$display("test fast gate done");
		wr(8'h08, 8'h08, r);
		wr(8'h00, 8'h08, r);
		rd(8'h00, d, r);
		chk("set unarmed", d, 32'h00000000);
		wr(8'h00, 8'h08, r);
		rd(8'h00, d, r);
		chk("set armed", d, 32'h00000008);
		wr(8'h00, 8'h00, r);
		rd(8'h00, d, r);
		chk("clear by write", d, 32'h00000000);
		wr(8'h00, 8'h08, r);
		host.pulse_reset();
		rd(8'h00, d, r);
		chk("clear by soft reset", d, 32'h00000000);
		wr(8'h00, 8'h28, r);
		host.set_pd(1'b0);
		repeat (4) @(posedge clock);
		host.probe(16'h0060, 1'b0);
		@(negedge clock);
		chk("shutdown", 32'(hw_shutdown), 32'h1);
		chk("shut enable", 32'(host_if_enable), 32'h0);
		chk("shut hit", 32'(host_hit), 32'h00000000);
		host.set_pd(1'b1);
		repeat (4) @(posedge clock);
		@(negedge clock);
		chk("shutdown off", 32'(hw_shutdown), 32'h0);
		rd(8'h00, d, r);
		chk("clear by release", d, 32'h00000020);
		$display("test shutdown done");
		// A mid-run hardware reset must clear every field, even an armed shutdown enable.
		wr(8'h00, 8'hF8, r);
		rd(8'h00, d, r);
		chk("pre reset", d, 32'h000000F8);
		@(posedge clock);
		resetn <= 1'b0;
		repeat (2) @(posedge clock);
		resetn <= 1'b1;
		rd(8'h00, d, r);
		chk("ctrl after reset", d, 32'h00000000);
		chk("ctrl rresp", 32'(r), 32'(lcesc_pkg::RESP_OKAY));
		rd(8'h04, d, r);
		chk("status after reset", d, 32'h0000000A);
		// Only byte lane 0 carries the register; a write without it must leave it alone.
		lanes = 4'h0;
		wr(8'h00, 8'hE8, r);
		lanes = 4'h1;
		chk("no lane wresp", 32'(r), 32'(lcesc_pkg::RESP_OKAY));
		rd(8'h00, d, r);
		chk("no lane write", d, 32'h00000000);
		$display("test reset and strobe done");
		conclude();
	end
endmodule // tb_top
`default_nettype wire
